// file: verilog/mcu_exec_pkg.sv
`default_nettype none
package mcu_exec_pkg;
   // word and address widths, stack depth
   localparam int IW = 13;
   localparam int PW = 12;
   localparam int SD = 8;
   // major opcode groups in ir[12:11]
   localparam logic [1:0] G_REG = 2'h0, G_BIT = 2'h1, G_JMP = 2'h2, G_LIT = 2'h3;
   // register group function in ir[10:7], destination in ir[6]
   localparam logic [3:0] F_MISC = 4'h0, F_CLR = 4'h1, F_SUB = 4'h2, F_DEC = 4'h3;
   localparam logic [3:0] F_OR = 4'h4, F_AND = 4'h5, F_XOR = 4'h6, F_ADD = 4'h7;
   localparam logic [3:0] F_MOV = 4'h8, F_COM = 4'h9, F_INC = 4'hA, F_DJZ = 4'hB;
   localparam logic [3:0] F_RRC = 4'hC, F_RLC = 4'hD, F_SWAP = 4'hE, F_JZ = 4'hF;
   // operand-free codes in ir[5:0] when ir[12:6] is zero
   localparam logic [5:0] M_CONTROL_WRITE_INSTR = 6'h02, M_SLEEP = 6'h03, M_WATCHDOG_CLEAR_INSTR = 6'h04;
   localparam logic [5:0] M_ENI = 6'h05, M_IRQ_DISABLE_INSTR = 6'h06, M_RET = 6'h07, M_RETURN_FROM_IRQ_INSTR = 6'h08;
   localparam logic [5:0] M_CONTROL_READ_INSTR = 6'h09, M_LONG_CALL_INSTR = 6'h0A, M_LONG_JUMP_INSTR = 6'h0B;
   // literal group function in ir[10:8]
   localparam logic [2:0] L_MOV = 3'h0, L_OR = 3'h1, L_AND = 3'h2, L_XOR = 3'h3;
   localparam logic [2:0] L_RETURN_WITH_LITERAL_INSTR = 3'h4, L_SUB = 3'h5, L_IO = 3'h6, L_EXT = 3'h7;
   // core register addresses and control register window
   localparam logic [5:0] R_PC = 6'h02, R_STAT = 6'h03, R_BSEL = 6'h04, R_TPTR = 6'h05;
   localparam logic [5:0] IO_LO = 6'h05, IO_HI = 6'h0F;
   localparam logic [1:0] TP_BANK = 2'h1;
   // status byte layout, bank field and table select positions
   localparam int ST_C = 0, ST_DC = 1, ST_Z = 2, ST_P = 3, ST_T = 4, ST_PG = 5;
   localparam int BS_LO = 6, TP_SEL = 7;
   // reset values
   localparam logic [PW-1:0] RST_PC = 12'h000;
   localparam logic [7:0] RST_ACC = 8'h00, RST_CORE_CONTROL_REG = 8'h00;
   localparam logic RST_T = 1'b1, RST_P = 1'b1;

   typedef enum logic [2:0] {MD_RUN, MD_FLUSH, MD_SKIP, MD_LONG_CALL_INSTR, MD_LONG_JUMP_INSTR, MD_TABLE} mode_e;

   typedef struct packed {
      logic ph;
      mode_e mode;
      logic [IW-1:0] ir;
      logic [7:0] a;
      logic [PW-1:0] pc;
      logic [2:0] sp;
      logic [SD-1:0][PW-1:0] stk;
      logic z, c, dc, t, p;
      logic [1:0] page, bank;
      logic [7:0] tp, core_control_reg, da, dwd, iwd;
      logic dwe, iwe, watchdog_clear_instr, gie, sleep;
      logic [2:0] sy;
   } core_s;
endpackage : mcu_exec_pkg
`default_nettype wire

// file: verilog/mcu_instruction_execute_unit.sv
// Overview of operation
// - decode 13-bit words into opcode and operands
// - two clocks per cycle, one cycle normally
// - program counter writes cost an extra cycle
// - any bit of any register testable; settable, clearable except status T/P and bank select bits 0-5
// - core registers behave as general registers
// - bank select bits 6,7 choose register bank
// - 8-bit data literals, 10-bit jump targets
// - sleep/watchdog clear reset watchdog, set T; sleep clears P, watchdog clear sets P
// - returns pop; irq return and enable/disable
// - control register moves, defined range only
// - add A+R, subtract R-A, set Z,C,DC
// - logic, inc/dec, clear, moves touch only Z
// - inc/dec skip on zero, flags untouched
// - rotates through carry, carry flag only
// - call pushes PC+1; jumps load page+literal
// - return with literal loads A and pops
// - table read low byte or high bits
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_unit
   import mcu_exec_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic [IW-1:0] pm_data_in,
   input wire logic [7:0] dm_rdata_in,
   input wire logic [7:0] io_rdata_in,
   input wire logic wake_in,
   output logic [PW-1:0] pm_addr_out,
   output logic [7:0] dm_addr_out,
   output logic dm_we_out,
   output logic [7:0] dm_wdata_out,
   output logic io_we_out,
   output logic [7:0] io_wdata_out,
   output logic wdt_clear_out,
   output logic sleep_out,
   output logic irq_enable_out,
   output logic [7:0] core_control_out,
   output logic [7:0] status_out,
   output logic [7:0] acc_out
);

   core_s q, n;
   logic [7:0] rv, op, res, alu_r;
   logic [5:0] r;
   logic [3:0] fn;
   logic [8:0] t9;
   logic [4:0] t5;
   logic alu_c, alu_dc, alu_z, alu_cw, alu_zw;
   logic wr_r, wr_a, fl, do_push, do_pop, ex;
   logic [PW-1:0] pc1, push_val;

   // status byte as software sees it
   function automatic logic [7:0] stat_byte(input core_s s);
      logic [7:0] v;
      v = 8'h00;
      v[ST_C] = s.c;
      v[ST_DC] = s.dc;
      v[ST_Z] = s.z;
      v[ST_P] = s.p;
      v[ST_T] = s.t;
      v[ST_PG +: 2] = s.page;
      return v;
   endfunction : stat_byte

   // register read: core registers internal, everything else external
   function automatic logic [7:0] reg_rd(input core_s s, input logic [7:0] ext);
      logic [5:0] a;
      a = s.da[5:0];
      if (a == R_PC) return s.pc[7:0];
      else if (a == R_STAT) return stat_byte(s);
      else if (a == R_BSEL) return {s.bank, 6'h00};
      else if (a == R_TPTR && s.da[7:6] == TP_BANK) return s.tp;
      else return ext;
   endfunction : reg_rd

   // control register window check, used by decode and checks
   function automatic logic io_ok(input logic [5:0] a);
      return a >= IO_LO && a <= IO_HI;
   endfunction : io_ok

   // memory-side outputs; table cycles fetch from table pointer bits 3:0 and A
   assign pm_addr_out = (q.mode == MD_TABLE) ? {q.tp[3:0], q.a} : q.pc;
   assign dm_addr_out = q.da;
   assign dm_we_out = q.dwe;
   assign dm_wdata_out = q.dwd;
   assign io_we_out = q.iwe;
   assign io_wdata_out = q.iwd;
   assign wdt_clear_out = q.watchdog_clear_instr;
   assign sleep_out = q.sleep;
   assign irq_enable_out = q.gie;
   assign core_control_out = q.core_control_reg;
   assign status_out = stat_byte(q);
   assign acc_out = q.a;
   assign ex = q.ph && !q.sleep && q.mode == MD_RUN;

   // next-state logic: fetch on phase 0, execute on phase 1
   always_comb begin
      n = q;
      n.dwe = 1'b0;
      n.iwe = 1'b0;
      n.watchdog_clear_instr = 1'b0;
      n.sy = {q.sy[1:0], wake_in};
      r = q.da[5:0];
      rv = reg_rd(q, dm_rdata_in);
      pc1 = q.pc + 12'h001;
      res = 8'h00;
      wr_r = 1'b0;
      wr_a = 1'b0;
      fl = 1'b0;
      do_push = 1'b0;
      do_pop = 1'b0;
      push_val = pc1;
      // literal group reuses the register alu functions
      if (q.ir[12:11] == G_LIT) begin
         op = q.ir[7:0];
         unique case (q.ir[10:8])
            L_OR: fn = F_OR;
            L_AND: fn = F_AND;
            L_XOR: fn = F_XOR;
            L_SUB: fn = F_SUB;
            default: fn = F_MOV;
         endcase
      end else begin
         op = rv;
         fn = q.ir[10:7];
      end
      // alu: flag enables say which flags the function may touch
      t9 = 9'h000;
      t5 = 5'h00;
      alu_c = q.c;
      alu_dc = q.dc;
      alu_cw = 1'b0;
      alu_zw = 1'b1;
      unique case (fn)
         F_MISC: begin
            alu_r = q.a;
            alu_zw = 1'b0;
         end
         F_CLR: alu_r = 8'h00;
         F_SUB: begin
            t9 = {1'b0, op} - {1'b0, q.a};
            t5 = {1'b0, op[3:0]} - {1'b0, q.a[3:0]};
            alu_r = t9[7:0];
            alu_c = ~t9[8];
            alu_dc = ~t5[4];
            alu_cw = 1'b1;
         end
         F_ADD: begin
            t9 = {1'b0, q.a} + {1'b0, op};
            t5 = {1'b0, q.a[3:0]} + {1'b0, op[3:0]};
            alu_r = t9[7:0];
            alu_c = t9[8];
            alu_dc = t5[4];
            alu_cw = 1'b1;
         end
         F_DEC: alu_r = op - 8'h01;
         F_OR: alu_r = q.a | op;
         F_AND: alu_r = q.a & op;
         F_XOR: alu_r = q.a ^ op;
         F_MOV: alu_r = op;
         F_COM: alu_r = ~op;
         F_INC: alu_r = op + 8'h01;
         F_DJZ: begin
            alu_r = op - 8'h01;
            alu_zw = 1'b0;
         end
         F_JZ: begin
            alu_r = op + 8'h01;
            alu_zw = 1'b0;
         end
         F_RRC: begin
            alu_r = {q.c, op[7:1]};
            alu_c = op[0];
            alu_cw = 1'b1;
            alu_zw = 1'b0;
         end
         F_RLC: begin
            alu_r = {op[6:0], q.c};
            alu_c = op[7];
            alu_cw = 1'b1;
            alu_zw = 1'b0;
         end
         F_SWAP: begin
            alu_r = {op[3:0], op[7:4]};
            alu_zw = 1'b0;
         end
      endcase
      alu_z = alu_r == 8'h00;

      if (q.sleep) begin
         // oscillator stopped; a settled wake level restarts the core
         if (q.sy[1] && q.sy[2]) n.sleep = 1'b0;
      end else if (!q.ph) begin
         n.ph = 1'b1;
         n.ir = pm_data_in;
         // table cycles keep the latched target register address
         if (q.mode != MD_TABLE) n.da = {q.bank, pm_data_in[5:0]};
      end else begin
         n.ph = 1'b0;
         unique case (q.mode)
            MD_FLUSH: n.mode = MD_RUN;
            MD_SKIP: begin
               n.pc = pc1;
               n.mode = MD_RUN;
            end
            MD_LONG_CALL_INSTR, MD_LONG_JUMP_INSTR: begin
               // second word carries the full target
               n.pc = q.ir[PW-1:0];
               do_push = q.mode == MD_LONG_CALL_INSTR;
               n.mode = MD_RUN;
            end
            MD_TABLE: begin
               res = q.tp[TP_SEL] ? {3'h0, q.ir[12:8]} : q.ir[7:0];
               wr_r = 1'b1;
               n.mode = MD_RUN;
            end
            MD_RUN: begin
               n.pc = pc1;
               unique case (q.ir[12:11])
                  G_REG: begin
                     if (fn == F_MISC && !q.ir[6]) begin
                        if (q.ir[10:6] == 5'h00) begin
                           unique case (q.ir[5:0])
                              M_CONTROL_WRITE_INSTR: n.core_control_reg = q.a;
                              M_SLEEP: begin
                                 n.watchdog_clear_instr = 1'b1;
                                 n.t = 1'b1;
                                 n.p = 1'b0;
                                 n.sleep = 1'b1;
                              end
                              M_WATCHDOG_CLEAR_INSTR: begin
                                 n.watchdog_clear_instr = 1'b1;
                                 n.t = 1'b1;
                                 n.p = 1'b1;
                              end
                              M_ENI: n.gie = 1'b1;
                              M_IRQ_DISABLE_INSTR: n.gie = 1'b0;
                              M_RET: do_pop = 1'b1;
                              M_RETURN_FROM_IRQ_INSTR: begin
                                 do_pop = 1'b1;
                                 n.gie = 1'b1;
                              end
                              M_CONTROL_READ_INSTR: begin
                                 res = q.core_control_reg;
                                 wr_a = 1'b1;
                              end
                              M_LONG_CALL_INSTR: n.mode = MD_LONG_CALL_INSTR;
                              M_LONG_JUMP_INSTR: n.mode = MD_LONG_JUMP_INSTR;
                              default: ;
                           endcase
                        end
                     end else begin
                        res = alu_r;
                        wr_r = q.ir[6];
                        wr_a = !q.ir[6];
                        fl = 1'b1;
                        if ((fn == F_DJZ || fn == F_JZ) && alu_z) n.mode = MD_SKIP;
                     end
                  end
                  G_BIT: begin
                     unique case (q.ir[10:9])
                        2'h0: begin
                           res = rv & ~(8'h01 << q.ir[8:6]);
                           wr_r = 1'b1;
                        end
                        2'h1: begin
                           res = rv | (8'h01 << q.ir[8:6]);
                           wr_r = 1'b1;
                        end
                        2'h2: if (!rv[q.ir[8:6]]) n.mode = MD_SKIP;
                        2'h3: if (rv[q.ir[8:6]]) n.mode = MD_SKIP;
                     endcase
                  end
                  G_JMP: begin
                     n.pc = {q.page, q.ir[9:0]};
                     do_push = !q.ir[10];
                     n.mode = MD_FLUSH;
                  end
                  G_LIT: begin
                     unique case (q.ir[10:8])
                        L_MOV: begin
                           res = op;
                           wr_a = 1'b1;
                        end
                        L_RETURN_WITH_LITERAL_INSTR: begin
                           res = op;
                           wr_a = 1'b1;
                           do_pop = 1'b1;
                        end
                        L_IO: begin
                           // outside the window the access is dropped
                           if (io_ok(q.ir[5:0]) && q.ir[7]) begin
                              res = io_rdata_in;
                              wr_a = 1'b1;
                           end else if (io_ok(q.ir[5:0])) begin
                              n.iwe = 1'b1;
                              n.iwd = q.a;
                           end
                        end
                        L_EXT: begin
                           if (q.ir[7]) n.mode = MD_TABLE;
                           else n.bank = q.ir[1:0];
                        end
                        default: begin
                           res = alu_r;
                           wr_a = 1'b1;
                           fl = 1'b1;
                        end
                     endcase
                  end
               endcase
            end
         endcase
         // stack: returns pop into the counter and take the slow path
         if (do_push) begin
            n.stk[q.sp] = push_val;
            n.sp = q.sp + 3'h1;
         end
         if (do_pop) begin
            n.sp = q.sp - 3'h1;
            n.pc = q.stk[q.sp - 3'h1];
            n.mode = MD_FLUSH;
         end
         if (wr_a) n.a = res;
         // register write-back; core registers never reach the data port
         if (wr_r) begin
            if (r == R_PC) begin
               n.pc = {q.pc[PW-1:8], res};
               n.mode = MD_FLUSH;
            end else if (r == R_STAT) begin
               // timeout and power-down are read only
               n.c = res[ST_C];
               n.dc = res[ST_DC];
               n.z = res[ST_Z];
               n.page = res[ST_PG +: 2];
            end else if (r == R_BSEL) begin
               n.bank = res[BS_LO +: 2];
            end else if (r == R_TPTR && q.da[7:6] == TP_BANK) begin
               n.tp = res;
            end else begin
               n.dwe = 1'b1;
               n.dwd = res;
            end
         end
         // flags win over an explicit status write in the same cycle
         if (fl && alu_zw) n.z = alu_z;
         if (fl && alu_cw) begin
            n.c = alu_c;
            n.dc = alu_dc;
         end
      end
   end

   // the only state register
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
         q.mode <= MD_RUN;
         q.pc <= RST_PC;
         q.a <= RST_ACC;
         q.core_control_reg <= RST_CORE_CONTROL_REG;
         q.t <= RST_T;
         q.p <= RST_P;
      end else begin
         q <= n;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence flush_then_run;
      (q.mode == MD_FLUSH) [*2] ##1 (q.mode == MD_RUN);
   endsequence

   phase_toggle_a: assert property (!q.sleep && !q.ph |=> q.ph)
      else $error("fetch not followed by execute");
   pc_write_slow_a: assert property (ex && wr_r && r == R_PC |=> flush_then_run)
      else $error("pc write did not insert one dead cycle");
   sleep_wdt_a: assert property (ex && q.ir == {7'h00, M_SLEEP} |=> wdt_clear_out && sleep_out && !q.p && q.t)
      else $error("sleep did not clear watchdog or set flags");
   bank_addr_a: assert property (!q.ph && !q.sleep && q.mode != MD_TABLE
      |=> q.da == {$past(q.bank), $past(pm_data_in[5:0])})
      else $error("register address not banked");
   skip_flags_a: assert property (ex && q.ir[12:11] == G_REG && fn == F_DJZ && alu_z
      |=> q.mode == MD_SKIP && $stable(q.c) && $stable(q.z) && $stable(q.dc))
      else $error("decrement skip wrong");
   rrc_carry_a: assert property (ex && q.ir[12:11] == G_REG && fn == F_RRC && r != R_STAT
      |=> q.c == $past(rv[0]) && $stable(q.z))
      else $error("rotate carry wrong");
   add_carry_a: assert property (ex && q.ir[12:11] == G_REG && fn == F_ADD
      |=> q.c == (({1'b0, $past(q.a)} + {1'b0, $past(rv)}) > 9'h0FF))
      else $error("add carry wrong");
   table_high_a: assert property (q.ph && !q.sleep && q.mode == MD_TABLE && q.tp[TP_SEL] && r > R_TPTR
      |=> dm_we_out && dm_wdata_out[7:5] == 3'h0)
      else $error("table read high bits not zero padded");
   call_push_a: assert property (ex && q.ir[12:10] == 3'h4
      |=> q.sp == $past(q.sp) + 3'h1 && q.stk[$past(q.sp)] == $past(pc1))
      else $error("call did not push pc plus one");
   io_range_a: assert property (ex && q.ir[12:8] == {G_LIT, L_IO} && !io_ok(q.ir[5:0])
      |=> !io_we_out && $stable(q.a))
      else $error("control access outside window");

endmodule : mcu_instruction_execute_unit
`default_nettype wire

// file: tb/prog_data_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_data_model
   import mcu_exec_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [PW-1:0] pm_addr_in,
   input wire logic [7:0] dm_addr_in,
   input wire logic dm_we_in,
   input wire logic [7:0] dm_wdata_in,
   input wire logic io_we_in,
   input wire logic [7:0] io_wdata_in,
   output logic [IW-1:0] pm_data_out,
   output logic [7:0] dm_rdata_out,
   output logic [7:0] io_rdata_out
);
   logic [IW-1:0] prog [0:(1<<PW)-1];
   logic [7:0] ram [0:255];
   logic [7:0] ioc [0:255];

   // answers within the clock, as the core samples on its own edge
   assign pm_data_out = prog[pm_addr_in];
   assign dm_rdata_out = ram[dm_addr_in];
   assign io_rdata_out = ioc[dm_addr_in];

   // writes land on the edge after the one-clock strobe
   always @(posedge sys_clk_in) begin
      if (dm_we_in) begin
         ram[dm_addr_in] <= dm_wdata_in;
      end
      if (io_we_in) begin
         ioc[dm_addr_in] <= io_wdata_in;
      end
   end

   // blank words decode as no-op, so stray fetches stay harmless
   task automatic clear;
      for (int i = 0; i < (1 << PW); i++) begin
         prog[i] = '0;
      end
      for (int i = 0; i < 256; i++) begin
         ram[i] = '0;
         ioc[i] = '0;
      end
   endtask : clear

   initial clear();
endmodule : prog_data_model
`default_nettype wire

// file: tb/mcu_instruction_execute_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_unit_bench
   import mcu_exec_pkg::*;
;
   logic sys_clk_in, rst_b_in, wake_in, dm_we, io_we, wdt_clr, sleep, irq_en;
   logic [IW-1:0] pm_data;
   logic [PW-1:0] pm_addr, hold;
   logic [7:0] dm_rd, io_rd, dm_addr, dm_wd, io_wd, ctrl, status, acc;
   int n_mismatch, total_checks, cycles, wp, n_wdt, n;

   mcu_instruction_execute_unit uut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pm_data_in(pm_data),
      .dm_rdata_in(dm_rd), .io_rdata_in(io_rd), .wake_in(wake_in), .pm_addr_out(pm_addr),
      .dm_addr_out(dm_addr), .dm_we_out(dm_we), .dm_wdata_out(dm_wd), .io_we_out(io_we),
      .io_wdata_out(io_wd), .wdt_clear_out(wdt_clr), .sleep_out(sleep), .irq_enable_out(irq_en),
      .core_control_out(ctrl), .status_out(status), .acc_out(acc));
   prog_data_model mem (.sys_clk_in(sys_clk_in), .pm_addr_in(pm_addr), .dm_addr_in(dm_addr),
      .dm_we_in(dm_we), .dm_wdata_in(dm_wd), .io_we_in(io_we), .io_wdata_in(io_wd),
      .pm_data_out(pm_data), .dm_rdata_out(dm_rd), .io_rdata_out(io_rd));

   // clock
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // ceiling against a hung core, and a count of watchdog-clear pulses
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (wdt_clr === 1'b1) begin
         n_wdt <= n_wdt + 1;
      end
      if (cycles == 6000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic note(input string name);
      $display("test %s done, mismatches %0d", name, n_mismatch);
   endtask : note

   // instruction word builders
   function automatic logic [IW-1:0] rop(input logic [3:0] f, input logic d, input logic [5:0] r);
      return {G_REG, f, d, r};
   endfunction : rop
   function automatic logic [IW-1:0] lit(input logic [2:0] f, input logic [7:0] k);
      return {G_LIT, f, k};
   endfunction : lit
   function automatic logic [IW-1:0] bop(input logic [1:0] op, input logic [2:0] b, input logic [5:0] r);
      return {G_BIT, op, b, r};
   endfunction : bop
   function automatic logic [IW-1:0] msc(input logic [5:0] m);
      return {7'h00, m};
   endfunction : msc

   task automatic emit(input logic [IW-1:0] w);
      mem.prog[wp] = w;
      wp++;
   endtask : emit

   // jump to itself: a quiet end of program
   task automatic halt;
      emit({G_JMP, 1'b1, wp[9:0]});
   endtask : halt

   // core held in reset while memories are blanked
   task automatic start;
      @(posedge sys_clk_in);
      rst_b_in <= 1'b0;
      @(posedge sys_clk_in);
      mem.clear();
      wp = 0;
      n_wdt = 0;
   endtask : start

   task automatic go;
      rst_b_in <= 1'b1;
      repeat (90) @(posedge sys_clk_in);
      #1;
   endtask : go

   task automatic wait_addr(input logic [PW-1:0] a, output int cnt);
      cnt = 0;
      while (pm_addr !== a && cnt < 60) begin
         @(posedge sys_clk_in);
         #1;
         cnt++;
      end
   endtask : wait_addr

   task automatic wait_sleep(input logic lvl);
      for (int i = 0; i < 20 && sleep !== lvl; i++) begin
         @(posedge sys_clk_in);
         #1;
      end
   endtask : wait_sleep

   initial begin
      rst_b_in = 1'b0;
      wake_in = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      cycles = 0;
      n_wdt = 0;
      repeat (4) @(posedge sys_clk_in);
      #1;
      check(status, 8'h18, "reset status");
      check({acc, ctrl}, 16'h0000, "reset acc");
      check({sleep, irq_en, dm_we, io_we, wdt_clr}, 5'h00, "reset pulses");
      note("reset");
      // add, subtract, status read back through a register operand
      start();
      mem.ram[8'h12] = 8'h20;
      emit(lit(L_MOV, 8'h0F));
      emit(rop(F_MISC, 1'b1, 6'h10));
      emit(msc(6'h3F));
      emit(rop(F_ADD, 1'b0, 6'h10));
      emit(rop(F_MOV, 1'b0, R_STAT));
      emit(rop(F_MISC, 1'b1, 6'h14));
      emit(lit(L_MOV, 8'hF1));
      emit(rop(F_MISC, 1'b1, 6'h11));
      emit(lit(L_MOV, 8'h0F));
      emit(rop(F_ADD, 1'b1, 6'h11));
      emit(rop(F_MOV, 1'b0, R_STAT));
      emit(rop(F_MISC, 1'b1, 6'h13));
      emit(rop(F_SUB, 1'b0, 6'h12));
      halt();
      go();
      check(mem.ram[8'h10], 8'h0F, "mov r");
      check(mem.ram[8'h14], 8'h1A, "half carry");
      check(mem.ram[8'h11], 8'h00, "add r");
      check(mem.ram[8'h13], 8'h1F, "all flags");
      check({acc, status[ST_Z]}, 9'h002, "sub");
      note("arith");
      // rotates through carry leave zero and half carry alone
      start();
      mem.ram[8'h13] = 8'h01;
      mem.ram[8'h12] = 8'h02;
      emit(lit(L_MOV, 8'hFF));
      emit(rop(F_ADD, 1'b0, 6'h13));
      emit(lit(L_OR, 8'h80));
      emit(rop(F_RRC, 1'b1, 6'h12));
      emit(rop(F_RLC, 1'b0, 6'h12));
      halt();
      go();
      check(mem.ram[8'h12], 8'h81, "rrc");
      check({acc, status[2:0]}, 11'h013, "rlc flags");
      note("rotate");
      // count-and-skip keeps the flags
      start();
      mem.ram[8'h15] = 8'h05;
      mem.ram[8'h14] = 8'h01;
      emit(rop(F_JZ, 1'b0, 6'h15));
      emit(lit(L_OR, 8'h10));
      emit(rop(F_DJZ, 1'b1, 6'h14));
      emit(lit(L_MOV, 8'h11));
      emit(lit(L_MOV, 8'h22));
      halt();
      go();
      check({mem.ram[8'h14], mem.ram[8'h15]}, 16'h0005, "skip regs");
      check({acc, status[ST_Z]}, 9'h044, "skip acc");
      note("skip");
      // bit set, clear and test, then a bank switch
      start();
      mem.ram[8'h17] = 8'hFF;
      emit(bop(2'h1, 3'h7, 6'h16));
      emit(bop(2'h0, 3'h0, 6'h17));
      emit(bop(2'h3, 3'h7, 6'h16));
      emit(lit(L_MOV, 8'h33));
      emit(bop(2'h2, 3'h0, 6'h17));
      emit(lit(L_MOV, 8'h44));
      emit(lit(L_EXT, 8'h02));
      emit(lit(L_MOV, 8'h5A));
      emit(rop(F_MISC, 1'b1, 6'h10));
      halt();
      go();
      check({mem.ram[8'h16], mem.ram[8'h17]}, 16'h80FE, "bits");
      check({mem.ram[8'h90], acc}, 16'h5A5A, "bank");
      note("bits");
      // calls, returns, interrupt enable
      start();
      emit({G_JMP, 1'b0, 10'h010});
      emit(rop(F_MISC, 1'b1, 6'h18));
      emit(msc(M_ENI));
      emit(msc(M_IRQ_DISABLE_INSTR));
      emit({G_JMP, 1'b0, 10'h020});
      emit(msc(M_LONG_CALL_INSTR));
      emit(13'h0030);
      emit(rop(F_MISC, 1'b1, 6'h19));
      emit(msc(M_LONG_JUMP_INSTR));
      emit(13'h0050);
      emit(lit(L_MOV, 8'h11));
      mem.prog[12'h010] = lit(L_RETURN_WITH_LITERAL_INSTR, 8'h77);
      mem.prog[12'h020] = msc(M_RETURN_FROM_IRQ_INSTR);
      mem.prog[12'h030] = lit(L_RETURN_WITH_LITERAL_INSTR, 8'h99);
      wp = 12'h050;
      halt();
      rst_b_in <= 1'b1;
      wait_addr(12'h003, n);
      check(irq_en, 1'b1, "enable");
      wait_addr(12'h004, n);
      check(irq_en, 1'b0, "disable");
      go();
      check(irq_en, 1'b1, "irq return");
      check({mem.ram[8'h18], mem.ram[8'h19]}, 16'h7799, "returns");
      check(acc, 8'h99, "long jump");
      note("flow");
      // control register window and core control byte
      start();
      emit(lit(L_MOV, 8'hA5));
      emit(lit(L_IO, 8'h06));
      emit(lit(L_IO, 8'h20));
      emit(msc(M_CONTROL_WRITE_INSTR));
      emit(lit(L_MOV, 8'h00));
      emit(msc(M_CONTROL_READ_INSTR));
      emit(rop(F_MISC, 1'b1, 6'h1A));
      emit(lit(L_MOV, 8'h00));
      emit(lit(L_IO, 8'h86));
      halt();
      go();
      check({mem.ioc[8'h06], mem.ioc[8'h20]}, 16'hA500, "ctrl write");
      check({ctrl, mem.ram[8'h1A]}, 16'hA5A5, "core ctrl");
      check(acc, 8'hA5, "ctrl read");
      note("ctrl");
      // table read, low byte then high bits
      start();
      mem.prog[12'h123] = 13'h1ABC;
      emit(lit(L_EXT, 8'h01));
      emit(lit(L_MOV, 8'h01));
      emit(rop(F_MISC, 1'b1, R_TPTR));
      emit(lit(L_MOV, 8'h23));
      emit(lit(L_EXT, 8'h90));
      emit(lit(L_MOV, 8'h81));
      emit(rop(F_MISC, 1'b1, R_TPTR));
      emit(lit(L_MOV, 8'h23));
      emit(lit(L_EXT, 8'h91));
      halt();
      go();
      check({mem.ram[8'h50], mem.ram[8'h51]}, 16'hBC1A, "table");
      note("table");
      // cycle counts: plain, program counter write, jump
      start();
      emit(msc(6'h00));
      emit(lit(L_MOV, 8'h08));
      emit(rop(F_MISC, 1'b1, R_PC));
      emit(lit(L_MOV, 8'hEE));
      wp = 8;
      emit(msc(6'h00));
      emit({G_JMP, 1'b1, 10'h00C});
      wp = 12;
      emit(msc(6'h00));
      halt();
      rst_b_in <= 1'b1;
      wait_addr(12'h001, n);
      wait_addr(12'h002, n);
      check(n, 2, "plain");
      wait_addr(12'h009, n);
      check(n, 6, "pc write");
      wait_addr(12'h00D, n);
      check(n, 6, "jump");
      check(acc, 8'h08, "flush");
      note("timing");
      // sleep, wake, watchdog clear
      start();
      emit(msc(M_SLEEP));
      emit(msc(M_WATCHDOG_CLEAR_INSTR));
      halt();
      rst_b_in <= 1'b1;
      wait_sleep(1'b1);
      check({sleep, status[ST_T], status[ST_P]}, 3'h6, "sleep flags");
      hold = pm_addr;
      repeat (10) @(posedge sys_clk_in);
      #1;
      check({pm_addr, sleep}, {hold, 1'b1}, "frozen");
      check(n_wdt, 1, "sleep clear");
      @(posedge sys_clk_in);
      wake_in <= 1'b1;
      wait_sleep(1'b0);
      @(posedge sys_clk_in);
      wake_in <= 1'b0;
      repeat (20) @(posedge sys_clk_in);
      #1;
      check({status[ST_T], status[ST_P]}, 2'h3, "wdt flags");
      check(n_wdt, 2, "wdt clear");
      note("sleep");
      complete_run();
   end
endmodule : mcu_instruction_execute_unit_bench
`default_nettype wire
